// ### dspm_block.sv
/*
 * Multiply/add/accumulate block: input registers with shift chains, four multiplier
 * sub-blocks, adder/accumulator/summation stage and output registers.
 * Assumes all inputs come from fabric logic clocked by clk_i; the four documented
 * register clocks are served by this one clock and the four clock enables.
 */
`timescale 1ns/1ps
// Behaviour
// - Simple mode outputs four 18x18 or eight 9x9 products, through output register.
// - 36x36 product built from four 18x18 products with shifts and one adder.
// - Shift chain inputs are disabled in 36x36 mode; operands load in parallel.
// - Post-multiply register serves as a pipeline stage of the 36x36 product.
// - Sign, add/sub and load controls delayed zero, one or two stages.
// - Two accumulators fed only by the second and fourth multiplier sub-blocks.
// - Accumulators are 52 bits: 36-bit product plus 16 guard bits.
// - Load input and overflow flag act only in accumulate mode.
// - Add/sub lets the accumulator subtract; overflow also flags underflow.
// - Two-multiplier adder gives two 18x18 or four 9x9 sums/differences.
// - Complex multiply: upper pair subtracts for real, lower pair adds for imaginary.
// - Four-multiplier adder sums both first-stage results, per width.
// - Data and coefficient shift chains plus four-multiplier adder form four-tap FIR.
// - 36x36 product supports only both signed or both unsigned operands.
// - Shift chains leave the block on dedicated outputs for cascading.
// - Eight 18-bit input units and eight 18-bit output units.
// - Control bundle: enables, clears, two signs, two add/subs, two loads.
// - Add/sub select high adds, low subtracts.
// - Load replaces accumulator contents with the current product.
// - Sign high means signed operand; product signed if either is signed.
// - Exactly one operating mode is active at a time.
module dspm_block #(
	parameter int unsigned GUARD = dspm_pkg::GUARD_W
) (
	input  wire logic                                     clk_i,
	input  wire logic                                     arst_n_i,
	input  wire dspm_pkg::dspm_cfg_s                      cfg_i,
	input  wire dspm_pkg::dspm_ctrl_s                     ctrl_i,
	input  wire dspm_pkg::dspm_word_t [dspm_pkg::SUBS-1:0] data_a_i,
	input  wire dspm_pkg::dspm_word_t [dspm_pkg::SUBS-1:0] data_b_i,
	input  wire dspm_pkg::dspm_word_t                     shift_in_a_i,
	input  wire dspm_pkg::dspm_word_t                     shift_in_b_i,
	output dspm_pkg::dspm_word_t [dspm_pkg::UNITS-1:0]    out_o,
	output logic [dspm_pkg::MACS-1:0]                     overflow_o,
	output dspm_pkg::dspm_word_t                          shift_out_a_o,
	output dspm_pkg::dspm_word_t                          shift_out_b_o
);
	import dspm_pkg::*;

	localparam int unsigned AW = PROD_W + GUARD;

	// The accumulator must fit in half of the output units.
	if (GUARD < 1 || AW > WIDE_W) begin : g_bad_guard
		$error("dspm_block: GUARD out of range");
	end

	function automatic logic [WIDE_W-1:0] ext_wide(input logic [PROD_W-1:0] p, input logic s);
		ext_wide = {{(WIDE_W-PROD_W){s & p[PROD_W-1]}}, p};
	endfunction : ext_wide

	function automatic logic [PROD_W-1:0] ext_half(input logic [UNIT_W-1:0] p, input logic s);
		ext_half = {{(PROD_W-UNIT_W){s & p[UNIT_W-1]}}, p};
	endfunction : ext_half

	dspm_word_t [SUBS-1:0] in_a_q, in_b_q;
	dspm_word_t [SUBS:0]   chain_a, chain_b;
	dspm_ctrl_s            ctrl_d1, ctrl_d2, eff;
	logic [PROD_W-1:0]     unit_p [SUBS];
	logic [UNIT_W-1:0]     half_p [UNITS];
	logic [AW-1:0]         acc_q  [MACS];
	logic [AW-1:0]         next_acc [MACS];
	logic [MACS-1:0]       next_ovf;
	logic [AW-1:0]         mac_prod [MACS];
	logic [AW+1:0]         acc_sum [MACS];
	logic [OUT_W-1:0]      out_q, next_out;
	logic [MACS-1:0]       ovf_q;

	wire is_w9     = (cfg_i.width == DSPM_W9);
	wire is_w36    = (cfg_i.width == DSPM_W36);
	wire is_mac    = (cfg_i.mode == DSPM_MAC);
	// Chains are only offered to the 9x9 and 18x18 widths.
	wire shift_a   = cfg_i.shift_a_en && !is_w36;
	wire shift_b   = cfg_i.shift_b_en && !is_w36;
	wire in_go     = ctrl_i.ena[GRP_IN] && !ctrl_i.clr[GRP_IN];
	wire out_go    = ctrl_i.ena[GRP_OUT] && !ctrl_i.clr[GRP_OUT];
	wire psign     = eff.sign_a | eff.sign_b;
	// Mixed signs are not offered at 36 bits, so sign_a speaks for both operands.
	wire sgn36     = eff.sign_a;
	wire sel_up    = eff.add_sub_select_upper;
	wire sel_lo    = eff.add_sub_select_lower;

	assign chain_a[0] = shift_in_a_i;
	assign chain_b[0] = shift_in_b_i;

	// Input registers and multiplier sub-blocks, one per 18x18 unit pair.
	for (genvar i = 0; i < SUBS; i++) begin : g_unit
		localparam int unsigned AI = i % 2;
		localparam int unsigned BI = i / 2;
		wire dspm_word_t next_a = shift_a ? chain_a[i] : data_a_i[i];
		wire dspm_word_t next_b = shift_b ? chain_b[i] : data_b_i[i];
		// At 36 bits unit i multiplies A half i%2 by B half i/2; low halves are unsigned.
		wire dspm_word_t op_a   = is_w36 ? in_a_q[AI] : in_a_q[i];
		wire dspm_word_t op_b   = is_w36 ? in_b_q[BI] : in_b_q[i];
		wire logic       s_a    = is_w36 ? (AI == 1 && sgn36) : eff.sign_a;
		wire logic       s_b    = is_w36 ? (BI == 1 && sgn36) : eff.sign_b;

		assign chain_a[i+1] = in_a_q[i];
		assign chain_b[i+1] = in_b_q[i];

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				in_a_q[i] <= WORD_RST;
				in_b_q[i] <= WORD_RST;
			end else if (ctrl_i.clr[GRP_IN]) begin
				in_a_q[i] <= WORD_RST;
				in_b_q[i] <= WORD_RST;
			end else if (ctrl_i.ena[GRP_IN]) begin
				in_a_q[i] <= next_a;
				in_b_q[i] <= next_b;
			end
		end

		// The pipeline register doubles as the inner stage of the wide product.
		dspm_mult_unit u_mult (
			.clk_i     (clk_i),
			.arst_n_i  (arst_n_i),
			.a_i       (op_a),
			.b_i       (op_b),
			.sign_a_i  (s_a),
			.sign_b_i  (s_b),
			.half_i    (is_w9),
			.pipe_en_i (cfg_i.pipe_en),
			.ena_i     (ctrl_i.ena[GRP_PIPE]),
			.clr_i     (ctrl_i.clr[GRP_PIPE]),
			.prod_o    (unit_p[i])
		);

		assign half_p[2*i]   = unit_p[i][UNIT_W-1:0];
		assign half_p[2*i+1] = unit_p[i][PROD_W-1:UNIT_W];
	end

	// Chain ends leave the block for the next one in the column.
	assign shift_out_a_o = in_a_q[SUBS-1];
	assign shift_out_b_o = in_b_q[SUBS-1];

	// Control latency selection lets the adder see controls aligned with its data.
	assign eff = (cfg_i.ctrl_lat == DSPM_LAT0) ? ctrl_i :
	             (cfg_i.ctrl_lat == DSPM_LAT1) ? ctrl_d1 : ctrl_d2;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_d1 <= '0;
			ctrl_d2 <= '0;
		end else if (ctrl_i.clr[GRP_CTRL]) begin
			ctrl_d1 <= '0;
			ctrl_d2 <= '0;
		end else if (ctrl_i.ena[GRP_CTRL]) begin
			ctrl_d1 <= ctrl_i;
			ctrl_d2 <= ctrl_d1;
		end
	end

	// First-level adders at 18 bits: select high adds, low subtracts.
	wire [WIDE_W-1:0] e0 = ext_wide(unit_p[0], psign);
	wire [WIDE_W-1:0] e1 = ext_wide(unit_p[1], psign);
	wire [WIDE_W-1:0] e2 = ext_wide(unit_p[2], psign);
	wire [WIDE_W-1:0] e3 = ext_wide(unit_p[3], psign);
	wire [WIDE_W-1:0] s18_0 = sel_up ? e0 + e1 : e0 - e1;
	wire [WIDE_W-1:0] s18_1 = sel_lo ? e2 + e3 : e2 - e3;

	// First-level adders at 9 bits: the upper select drives the top two adders.
	wire [PROD_W-1:0] h0 = ext_half(half_p[0], psign);
	wire [PROD_W-1:0] h1 = ext_half(half_p[1], psign);
	wire [PROD_W-1:0] h2 = ext_half(half_p[2], psign);
	wire [PROD_W-1:0] h3 = ext_half(half_p[3], psign);
	wire [PROD_W-1:0] h4 = ext_half(half_p[4], psign);
	wire [PROD_W-1:0] h5 = ext_half(half_p[5], psign);
	wire [PROD_W-1:0] h6 = ext_half(half_p[6], psign);
	wire [PROD_W-1:0] h7 = ext_half(half_p[7], psign);
	wire [PROD_W-1:0] s9_0 = sel_up ? h0 + h2 : h0 - h2;
	wire [PROD_W-1:0] s9_1 = sel_up ? h1 + h3 : h1 - h3;
	wire [PROD_W-1:0] s9_2 = sel_lo ? h4 + h6 : h4 - h6;
	wire [PROD_W-1:0] s9_3 = sel_lo ? h5 + h7 : h5 - h7;

	// Summation stage.
	wire [WIDE_W-1:0] t18   = s18_0 + s18_1;
	wire [PROD_W-1:0] t9_0  = s9_0 + s9_2;
	wire [PROD_W-1:0] t9_1  = s9_1 + s9_3;

	// Wide product: partial products aligned by 0, 18, 18 and 36 bit shifts.
	wire [WIDE_W-1:0] w0 = ext_wide(unit_p[0], 1'b0);
	wire [WIDE_W-1:0] w1 = ext_wide(unit_p[1], sgn36);
	wire [WIDE_W-1:0] w2 = ext_wide(unit_p[2], sgn36);
	wire [WIDE_W-1:0] w3 = ext_wide(unit_p[3], sgn36);
	wire [WIDE_W-1:0] wide = w0 + (w1 << UNIT_W) + (w2 << UNIT_W) + (w3 << PROD_W);

	// Accumulators: only sub-blocks 1 and 3 feed them; 0 and 2 idle.
	for (genvar j = 0; j < MACS; j++) begin : g_acc
		wire logic [PROD_W-1:0] src  = unit_p[2*j+1];
		wire logic              sel  = (j == 0) ? sel_up : sel_lo;
		wire logic              load = eff.accum_load[j];
		wire logic [AW+1:0]     xa   = {{2{psign & acc_q[j][AW-1]}}, acc_q[j]};
		wire logic [AW+1:0]     xp   = {{2{psign & mac_prod[j][AW-1]}}, mac_prod[j]};

		assign mac_prod[j] = {{GUARD{psign & src[PROD_W-1]}}, src};
		assign acc_sum[j]  = sel ? xa + xp : xa - xp;
		// The sum wraps at AW bits; the flag catches both carry out and borrow.
		assign next_acc[j] = load ? mac_prod[j] : acc_sum[j][AW-1:0];
		assign next_ovf[j] = !load && (psign ? (acc_sum[j][AW] ^ acc_sum[j][AW-1])
		                                     : acc_sum[j][AW]);

		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				acc_q[j] <= '0;
			end else if (ctrl_i.clr[GRP_OUT]) begin
				acc_q[j] <= '0;
			end else if (ctrl_i.ena[GRP_OUT] && is_mac) begin
				acc_q[j] <= next_acc[j];
			end
		end
	end

	wire [WIDE_W-1:0] acc0_x = {{(WIDE_W-AW){psign & acc_q[0][AW-1]}}, acc_q[0]};
	wire [WIDE_W-1:0] acc1_x = {{(WIDE_W-AW){psign & acc_q[1][AW-1]}}, acc_q[1]};
	wire [WIDE_W-1:0] nacc0  = {{(WIDE_W-AW){psign & next_acc[0][AW-1]}}, next_acc[0]};
	wire [WIDE_W-1:0] nacc1  = {{(WIDE_W-AW){psign & next_acc[1][AW-1]}}, next_acc[1]};

	// Output selection: the mode enum admits exactly one mode.
	always_comb begin
		next_out = '0;
		case (cfg_i.mode)
			DSPM_SIMPLE: begin
				next_out = is_w36 ? {{WIDE_W{1'b0}}, wide}
				                  : {unit_p[3], unit_p[2], unit_p[1], unit_p[0]};
			end
			DSPM_MAC: begin
				next_out = {nacc1, nacc0};
			end
			DSPM_ADD2: begin
				next_out = is_w9 ? {s9_3, s9_2, s9_1, s9_0} : {s18_1, s18_0};
			end
			DSPM_ADD4: begin
				next_out = is_w9 ? {{WIDE_W{1'b0}}, t9_1, t9_0} : {{WIDE_W{1'b0}}, t18};
			end
			default: begin
				next_out = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_q <= '0;
		end else if (ctrl_i.clr[GRP_OUT]) begin
			out_q <= '0;
		end else if (ctrl_i.ena[GRP_OUT]) begin
			out_q <= next_out;
		end
	end

	// Overflow is meaningless outside accumulate mode and is held low there.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ovf_q <= '0;
		end else if (!is_mac || ctrl_i.clr[GRP_OUT]) begin
			ovf_q <= '0;
		end else if (ctrl_i.ena[GRP_OUT]) begin
			ovf_q <= next_ovf;
		end
	end

	assign out_o      = out_q;
	assign overflow_o = ovf_q;

	// Reference helpers read only by the checks below.
	wire [AW:0] uns_sum0 = {1'b0, acc_q[0]} + {1'b0, mac_prod[0]};
	wire signed [WIDE_W+1:0] wide_ref = $signed({sgn36 & in_a_q[1][UNIT_W-1], in_a_q[1], in_a_q[0]})
	                                  * $signed({sgn36 & in_b_q[1][UNIT_W-1], in_b_q[1], in_b_q[0]});

	chk_load_acc: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		is_mac && out_go && eff.accum_load[0] |=> acc_q[0] == $past(mac_prod[0]))
		else $error("accumulator did not load the product");

	chk_acc_wrap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		is_mac && out_go && !eff.accum_load[0] && sel_up
		|=> acc_q[0] == AW'($past(acc_q[0]) + $past(mac_prod[0])))
		else $error("accumulator add did not wrap at its width");

	chk_acc_sub: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		is_mac && out_go && !eff.accum_load[1] && !sel_lo
		|=> acc_q[1] == AW'($past(acc_q[1]) - $past(mac_prod[1])))
		else $error("accumulator subtract wrong");

	chk_ovf_carry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		is_mac && out_go && !eff.accum_load[0] && sel_up && !psign
		|=> overflow_o[0] == $past(uns_sum0[AW]))
		else $error("unsigned overflow flag wrong");

	chk_ovf_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!is_mac |=> overflow_o == '0)
		else $error("overflow raised outside accumulate mode");

	chk_wide_prod: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		is_w36 && cfg_i.mode == DSPM_SIMPLE && !cfg_i.pipe_en && out_go
		|=> out_q[WIDE_W-1:0] == $past(wide_ref[WIDE_W-1:0]))
		else $error("wide product wrong");

	chk_wide_noshift: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		is_w36 && cfg_i.shift_a_en && in_go |=> in_a_q[1] == $past(data_a_i[1]))
		else $error("shift chain active at 36 bits");

	chk_chain_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		shift_a && in_go ##1 shift_a && in_go ##1 shift_a && in_go
		|=> shift_out_a_o == $past(in_a_q[0], 3))
		else $error("shift chain did not advance");

	chk_simple_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cfg_i.mode == DSPM_SIMPLE && !is_w36 && out_go
		|=> out_q[2*PROD_W-1:PROD_W] == $past(unit_p[1]))
		else $error("simple product not passed out");

	chk_ctrl_lat2: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(cfg_i.ctrl_lat == DSPM_LAT2 && ctrl_i.ena[GRP_CTRL] && !ctrl_i.clr[GRP_CTRL])[*2]
		|=> eff.sign_a == $past(ctrl_i.sign_a, 2))
		else $error("control delay of two stages wrong");

	cov_mac_ovf:  cover property (@(posedge clk_i) disable iff (!arst_n_i) is_mac && overflow_o[0]);
	cov_add4_18:  cover property (@(posedge clk_i) disable iff (!arst_n_i)
		cfg_i.mode == DSPM_ADD4 && cfg_i.width == DSPM_W18 && out_go);
	cov_wide:     cover property (@(posedge clk_i) disable iff (!arst_n_i) is_w36 && out_go);
	cov_fir:      cover property (@(posedge clk_i) disable iff (!arst_n_i)
		shift_a && shift_b && cfg_i.mode == DSPM_ADD4 && in_go);

endmodule : dspm_block

// ### dspm_pkg.sv
/*
 * Shared constants, mode encodings and signal bundles for the multiply/add/accumulate block.
 * Assumes a single clock domain; all inputs are driven by fabric logic on that clock.
 */
package dspm_pkg;

	localparam int unsigned UNIT_W  = 18;
	localparam int unsigned HALF_W  = 9;
	localparam int unsigned UNITS   = 8;
	localparam int unsigned SUBS    = 4;
	localparam int unsigned PROD_W  = 36;
	localparam int unsigned GUARD_W = 16;
	localparam int unsigned ACC_W   = 52;
	localparam int unsigned WIDE_W  = 72;
	localparam int unsigned OUT_W   = 144;
	localparam int unsigned MACS    = 2;

	// Clock enable and clear group assignment.
	localparam int unsigned GRP_IN   = 0;
	localparam int unsigned GRP_PIPE = 1;
	localparam int unsigned GRP_OUT  = 2;
	localparam int unsigned GRP_CTRL = 3;

	localparam logic [UNIT_W-1:0] WORD_RST = 18'h00000;

	typedef enum logic [3:0] {
		DSPM_SIMPLE = 4'h1,
		DSPM_MAC    = 4'h2,
		DSPM_ADD2   = 4'h4,
		DSPM_ADD4   = 4'h8
	} dspm_mode_e;

	typedef enum logic [2:0] {
		DSPM_W9  = 3'h1,
		DSPM_W18 = 3'h2,
		DSPM_W36 = 3'h4
	} dspm_width_e;

	typedef enum logic [2:0] {
		DSPM_LAT0 = 3'h1,
		DSPM_LAT1 = 3'h2,
		DSPM_LAT2 = 3'h4
	} dspm_lat_e;

	typedef logic [UNIT_W-1:0] dspm_word_t;

	typedef struct packed {
		logic [3:0] ena;
		logic [3:0] clr;
		logic       sign_a;
		logic       sign_b;
		logic       add_sub_select_upper;
		logic       add_sub_select_lower;
		logic [1:0] accum_load;
	} dspm_ctrl_s;

	typedef struct packed {
		dspm_mode_e  mode;
		dspm_width_e width;
		logic        shift_a_en;
		logic        shift_b_en;
		logic        pipe_en;
		dspm_lat_e   ctrl_lat;
	} dspm_cfg_s;

endpackage : dspm_pkg

// ### dspm_mult_unit.sv
/*
 * One 18x18 multiplier sub-block, splittable into two 9x9 multipliers, with its
 * optional post-multiply pipeline register.
 * Assumes operands come from registers on the same clock.
 */
`timescale 1ns/1ps
module dspm_mult_unit (
	input  wire logic                       clk_i,
	input  wire logic                       arst_n_i,
	input  wire dspm_pkg::dspm_word_t       a_i,
	input  wire dspm_pkg::dspm_word_t       b_i,
	input  wire logic                       sign_a_i,
	input  wire logic                       sign_b_i,
	input  wire logic                       half_i,
	input  wire logic                       pipe_en_i,
	input  wire logic                       ena_i,
	input  wire logic                       clr_i,
	output logic [dspm_pkg::PROD_W-1:0]     prod_o
);
	import dspm_pkg::*;

	logic signed [UNIT_W:0]     full_a;
	logic signed [UNIT_W:0]     full_b;
	logic signed [2*UNIT_W+1:0] full_p;
	logic signed [HALF_W:0]     lo_a, lo_b, hi_a, hi_b;
	logic signed [2*HALF_W+1:0] lo_p, hi_p;
	logic        [PROD_W-1:0]   comb_p;
	logic        [PROD_W-1:0]   pipe_q;

	// A signed operand extends with its top bit, an unsigned one with zero.
	assign full_a = {sign_a_i & a_i[UNIT_W-1], a_i};
	assign full_b = {sign_b_i & b_i[UNIT_W-1], b_i};
	assign full_p = full_a * full_b;
	assign lo_a   = {sign_a_i & a_i[HALF_W-1], a_i[HALF_W-1:0]};
	assign lo_b   = {sign_b_i & b_i[HALF_W-1], b_i[HALF_W-1:0]};
	assign hi_a   = {sign_a_i & a_i[UNIT_W-1], a_i[UNIT_W-1:HALF_W]};
	assign hi_b   = {sign_b_i & b_i[UNIT_W-1], b_i[UNIT_W-1:HALF_W]};
	assign lo_p   = lo_a * lo_b;
	assign hi_p   = hi_a * hi_b;
	assign comb_p = half_i ? {hi_p[UNIT_W-1:0], lo_p[UNIT_W-1:0]} : full_p[PROD_W-1:0];
	assign prod_o = pipe_en_i ? pipe_q : comb_p;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pipe_q <= '0;
		end else if (clr_i) begin
			pipe_q <= '0;
		end else if (ena_i) begin
			pipe_q <= comb_p;
		end
	end

endmodule : dspm_mult_unit

// ### dspm_fabric.sv
/*
 * Model of the fabric logic that feeds operands and shift-chain words to the block.
 * Assumes one clock; hold and corner requests are taken at the rising edge.
 */
`timescale 1ns/1ps
module dspm_fabric (
	input  wire logic                                      clk_i,
	input  wire logic                                      hold_i,
	input  wire logic                                      corner_i,
	output dspm_pkg::dspm_word_t [dspm_pkg::SUBS-1:0]      data_a_o,
	output dspm_pkg::dspm_word_t [dspm_pkg::SUBS-1:0]      data_b_o,
	output dspm_pkg::dspm_word_t                           shift_a_o,
	output dspm_pkg::dspm_word_t                           shift_b_o
);
	import dspm_pkg::*;
	integer seed = 89350;
	logic   h;
	logic   c;
	initial {data_a_o, data_b_o, shift_a_o, shift_b_o} = '0;
	// Controls are latched at the edge so the bench can change them after it without a race.
	always @(posedge clk_i) begin
		h = hold_i;
		c = corner_i;
		#1;
		// All units share one word width, set by the bench for the whole block
		for (int i = 0; i < SUBS; i++) begin
			data_a_o[i] = c ? 18'h3ffff : (h ? data_a_o[i] : 18'($random(seed)));
			data_b_o[i] = c ? 18'h3ffff : (h ? data_b_o[i] : 18'($random(seed)));
		end
		shift_a_o = 18'($random(seed));
		shift_b_o = 18'($random(seed));
	end
endmodule : dspm_fabric

// ### dspm_block_test.sv
/*
 * Self-checking bench for the multiply/add/accumulate block.
 * Assumes the fabric model supplies operands; a narrow guard width keeps wrap tests short.
 */
`timescale 1ns/1ps
module dspm_block_test;
	import dspm_pkg::*;
	localparam int          AW  = 38;
	localparam logic [71:0] MSK = (72'h1 << AW) - 72'h1;
	logic                   clk_i;
	logic                   arst_n_i;
	logic                   hold;
	logic                   corner;
	dspm_cfg_s              cfg;
	dspm_ctrl_s             ctrl;
	dspm_word_t [SUBS-1:0]  da;
	dspm_word_t [SUBS-1:0]  db;
	dspm_word_t [SUBS-1:0]  ha [3];
	dspm_word_t [SUBS-1:0]  hb [3];
	dspm_word_t             sia, sib, soa, sob;
	dspm_word_t             hsa [4];
	dspm_word_t             hsb [4];
	dspm_word_t [UNITS-1:0] out;
	logic [MACS-1:0]        ovf;
	logic [143:0]           pv;
	logic [71:0]            pa, pb, s0, d1;
	int                     error_cnt = 0;
	int                     n_checks = 0;
	integer                 seed = 89350;
	dspm_mode_e             ml [3] = '{DSPM_SIMPLE, DSPM_ADD2, DSPM_ADD4};
	dspm_width_e            wl [3] = '{DSPM_W9, DSPM_W18, DSPM_W36};

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	dspm_fabric FAB (.clk_i(clk_i), .hold_i(hold), .corner_i(corner), .data_a_o(da),
		.data_b_o(db), .shift_a_o(sia), .shift_b_o(sib));
	dspm_block #(.GUARD(AW - 36)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_i(cfg),
		.ctrl_i(ctrl), .data_a_i(da), .data_b_i(db), .shift_in_a_i(sia), .shift_in_b_i(sib),
		.out_o(out), .overflow_o(ovf), .shift_out_a_o(soa), .shift_out_b_o(sob));

	// Operands as taken at each edge; index 0 is the newest.
	always @(posedge clk_i) begin
		ha <= '{da, ha[0], ha[1]};
		hb <= '{db, hb[0], hb[1]};
		hsa <= '{sia, hsa[0], hsa[1], hsa[2]};
		hsb <= '{sib, hsb[0], hsb[1], hsb[2]};
	end

	function automatic logic [71:0] mul(logic [35:0] a, logic [35:0] b, int w, logic sa,
		logic sb);
		logic [71:0] x;
		logic [71:0] y;
		for (int i = 0; i < 72; i++) begin
			x[i] = (i < w) ? a[i] : (sa & a[w-1]);
			y[i] = (i < w) ? b[i] : (sb & b[w-1]);
		end
		return x * y;
	endfunction : mul

	function automatic logic [143:0] expect_out(dspm_word_t [3:0] a, dspm_word_t [3:0] b);
		logic [71:0]  p [4];
		logic [71:0]  q [8];
		logic [71:0]  t [4];
		logic [71:0]  u0, u1;
		logic [143:0] r;
		logic         sa, sb, up, lo;
		sa = ctrl.sign_a;
		sb = ctrl.sign_b;
		up = ctrl.add_sub_select_upper;
		lo = ctrl.add_sub_select_lower;
		r = '0;
		for (int i = 0; i < 4; i++) begin
			p[i] = mul(36'(a[i]), 36'(b[i]), 18, sa, sb);
			q[2*i] = mul(36'(a[i][8:0]), 36'(b[i][8:0]), 9, sa, sb);
			q[2*i+1] = mul(36'(a[i][17:9]), 36'(b[i][17:9]), 9, sa, sb);
		end
		for (int k = 0; k < 4; k++) begin
			t[k] = ((k < 2) ? up : lo) ? q[(k<2)?k:k+2] + q[(k<2)?k+2:k+4]
				: q[(k<2)?k:k+2] - q[(k<2)?k+2:k+4];
		end
		u0 = (up ? p[0] + p[1] : p[0] - p[1]);
		u1 = (lo ? p[2] + p[3] : p[2] - p[3]);
		if (cfg.mode == DSPM_SIMPLE && cfg.width == DSPM_W9) begin
			for (int k = 0; k < 8; k++) r[18*k+:18] = q[k][17:0];
		end else if (cfg.mode == DSPM_SIMPLE && cfg.width == DSPM_W18) begin
			for (int k = 0; k < 4; k++) r[36*k+:36] = p[k][35:0];
		end else if (cfg.mode == DSPM_SIMPLE) begin
			r[71:0] = mul({a[1], a[0]}, {b[1], b[0]}, 36, sa, sa);
		end else if (cfg.width == DSPM_W9 && cfg.mode == DSPM_ADD2) begin
			for (int k = 0; k < 4; k++) r[36*k+:36] = t[k][35:0];
		end else if (cfg.mode == DSPM_ADD2) begin
			r = {u1, u0};
		end else if (cfg.width == DSPM_W9) begin
			u0 = t[0] + t[2];
			u1 = t[1] + t[3];
			r[71:0] = {u1[35:0], u0[35:0]};
		end else begin
			r[71:0] = u0 + u1;
		end
		return r;
	endfunction : expect_out

	task automatic chk(logic [143:0] got, logic [143:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick

	task automatic close_out();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// Nothing waits on a handshake, so one overall bound covers any hang.
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		close_out();
	end

	initial begin
		arst_n_i = 1'b0;
		hold = 1'b0;
		corner = 1'b0;
		cfg = '{DSPM_SIMPLE, DSPM_W18, 1'b0, 1'b0, 1'b0, DSPM_LAT0};
		ctrl = '0;
		ctrl.ena = 4'hf;
		repeat (2) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		for (int mi = 0; mi < 3; mi++) begin
			for (int wi = 0; wi < 3; wi++) begin
				for (int c = 0; c < 16; c++) begin
					if (wi == 2 && mi != 0) continue;
					cfg.mode = ml[mi];
					cfg.width = wl[wi];
					cfg.pipe_en = c[0];
					cfg.shift_a_en = (wi == 2);
					ctrl.sign_a = c[1];
					ctrl.sign_b = (wi == 2) ? c[1] : c[2];
					ctrl.add_sub_select_upper = c[3];
					ctrl.add_sub_select_lower = c[0] ^ c[3];
					corner = (c[1:0] == 2'h3);
					ctrl.clr = 4'hf;
					tick();
					ctrl.clr = 4'h0;
					repeat (2) tick();
					repeat (2) begin
						tick();
						chk(out, expect_out(ha[1+c[0]], hb[1+c[0]]));
						chk(ovf, '0);
					end
				end
			end
		end
		cfg = '{DSPM_MAC, DSPM_W18, 1'b0, 1'b0, 1'b0, DSPM_LAT0};
		ctrl.sign_a = 1'b0;
		ctrl.sign_b = 1'b0;
		ctrl.accum_load = 2'h3;
		ctrl.clr = 4'hf;
		corner = 1'b0;
		tick();
		ctrl.clr = 4'h0;
		hold = 1'b1;
		repeat (3) tick();
		pa = mul(36'(ha[0][1]), 36'(hb[0][1]), 18, 1'b0, 1'b0);
		pb = mul(36'(ha[0][3]), 36'(hb[0][3]), 18, 1'b0, 1'b0);
		chk(out, {pb, pa});
		ctrl.accum_load = 2'h0;
		ctrl.add_sub_select_upper = 1'b1;
		ctrl.add_sub_select_lower = 1'b0;
		repeat (2) tick();
		// Held operands keep both products fixed; forty steps cross the narrow width often.
		repeat (40) begin
			pv = out;
			tick();
			s0 = pv[71:0] + pa;
			d1 = pv[143:72] - pb;
			chk(out, {d1 & MSK, s0 & MSK});
			chk(ovf, {d1[71], s0[AW]});
		end
		hold = 1'b0;
		// Two-stage control delay runs with random signs so its latency check is exercised.
		cfg = '{DSPM_SIMPLE, DSPM_W18, 1'b1, 1'b1, 1'b0, DSPM_LAT2};
		ctrl.clr = 4'hf;
		tick();
		ctrl.clr = 4'h0;
		repeat (3) tick();
		repeat (8) begin
			tick();
			ctrl.sign_a = 1'($random(seed));
			ctrl.sign_b = 1'($random(seed));
			chk({soa, sob}, {hsa[3], hsb[3]});
		end
		close_out();
	end
endmodule : dspm_block_test
